/* File: hdl/ccd_pkg.sv */
package ccd_pkg;
  localparam int CCD_NCTX = 32;
  localparam int CCD_NDW = 5;
  localparam logic [2:0] CCD_Q_CMD = 3'h0;
  localparam logic [2:0] CCD_Q_D0 = 3'h1;
  localparam logic [2:0] CCD_Q_D1 = 3'h2;
  localparam logic [2:0] CCD_Q_LAST_RW = 3'h4;
  localparam logic [2:0] CCD_Q_RES0 = 3'h6;
  localparam int CCD_CID_LSB = 56;
  localparam int CCD_HID_LSB = 48;
  localparam int CCD_SSR_LSB = 44;
  localparam int CCD_GMR_LSB = 40;
  localparam int CCD_PFX_LSB = 36;
  localparam int CCD_CMP_LSB = 32;
  localparam int CCD_IND_BIT = 29;
  localparam int CCD_LOC_LSB = 27;
  localparam int CCD_SIZE_LSB = 25;
  localparam int CCD_START_BIT = 24;
  localparam int CCD_NIB_LSB = 8;
  localparam int CCD_ADDR_LSB = 0;
  localparam int CCD_SEL_LSB = 19;
  localparam int CCD_RHID_LSB = 32;
  localparam int CCD_DONE_BIT = 31;
  localparam int CCD_ERR_BIT = 30;
  localparam int CCD_RCID_LSB = 24;
  typedef enum logic [2:0] {
    CCD_RD = 3'h0, CCD_WR = 3'h1, CCD_SE = 3'h2, CCD_LE = 3'h3,
    CCD_MV = 3'h4, CCD_SW = 3'h5, CCD_BAD6 = 3'h6, CCD_BAD7 = 3'h7
  } ccd_op_t;
  typedef enum logic [1:0] {
    CCD_X68 = 2'h0, CCD_X136 = 2'h1, CCD_X272 = 2'h2, CCD_XRSV = 2'h3
  } ccd_size_t;
  typedef enum logic [1:0] {
    CCD_LOC_DATA = 2'h0, CCD_LOC_MASK = 2'h1, CCD_LOC_SRAM = 2'h2, CCD_LOC_REGS = 2'h3
  } ccd_loc_t;
  typedef enum logic {CCD_IDLE = 1'b0, CCD_SEND = 1'b1} ccd_state_t;
  typedef struct packed {
    logic valid;
    ccd_op_t op;
    ccd_size_t size;
    ccd_loc_t loc;
    logic indirect;
    logic [4:0] sel;
    logic [15:0] addr;
    logic [4:0] slot;
    logic [4:0] cid;
    logic [4:0] hid;
    logic [1:0] beat;
    logic last;
    logic [2:0] global_mask_pair;
    logic [2:0] hit_index_register;
    logic [3:0] cmp;
    logic [2:0] pfx;
    logic [67:0] key;
    logic [63:0] param;
  } ccd_req_t;
  typedef struct packed {
    logic valid;
    logic [4:0] slot;
    logic err;
    logic [67:0] data;
  } ccd_rsp_t;
  localparam ccd_req_t CCD_REQ_IDLE = '0;
endpackage

/* File: hdl/ccd_top.sv */
`timescale 1ns/10ps
// Function
// - Comparand index only for Search and Learn
// - Forward address prefix into SSRAM address
// - Begin operation once start bit set
// - Size code selects 68, 136, 272 bits
// - Key word is data over nibble
// - Region code selects array, mask, SSRAM, registers
// - Direct/indirect bit selects hit-index addressing
// - Each nibble: layer attribute plus valid
// - Low command bits pick six operations
// - Read takes address and engine select
// - Read result returned in two words
// - Write uses command and two parameters
// - Write value is parameter over nibble
// - Search size sets descriptor words used
// - Search nibbles come from command word
// - Search indices taken from command word
// - Back-to-back searches are pipelined
// - Narrow host port halves throughput
// - Words 0-9 writable, 12-15 read only
// - Host identifier kept with context identifier
// - Wide search uses next mask pair, wrapping
module ccd_top
  import ccd_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic hp_wr,
  input wire logic hp_rd,
  input wire logic [8:0] hp_adr,
  input wire logic [63:0] hp_wdata,
  input wire logic hp_wide,
  output logic [63:0] hp_rdata,
  output logic hp_rvalid,
  output ccd_req_t eng_req,
  input wire ccd_rsp_t eng_rsp,
  output logic busy
);

  function automatic logic [7:0] ccd_idx(input logic [4:0] c, input logic [2:0] w);
    return ({3'h0, c} * 8'h05) + {5'h00, w};
  endfunction

  function automatic logic [4:0] ccd_pick(input logic [31:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [63:0] ccd_res0(input logic [63:0] cmd, input logic err, input logic [3:0] nib);
    logic [63:0] r;
    r = 64'h0;
    r[CCD_RHID_LSB +: 5] = cmd[CCD_HID_LSB +: 5];
    r[CCD_DONE_BIT] = 1'b1;
    r[CCD_ERR_BIT] = err;
    r[CCD_RCID_LSB +: 5] = cmd[CCD_CID_LSB +: 5];
    r[3:0] = nib;
    return r;
  endfunction

  logic [63:0] desc_r [0:CCD_NCTX*CCD_NDW-1];
  logic [63:0] res_r [0:2*CCD_NCTX-1];
  ccd_state_t state_r;
  ccd_state_t state_nxt;
  logic [4:0] cur_r;
  logic [4:0] cur_nxt;
  logic [1:0] beat_r;
  logic [1:0] beat_nxt;
  logic [31:0] pend_r;
  logic [31:0] pend_nxt;
  ccd_req_t req_r;
  ccd_req_t req_nxt;
  logic [63:0] hp_rdata_r;
  logic hp_rvalid_r;
  logic busy_r;

  // Host side: 64-bit words, or 32-bit halves when the port is narrow
  wire [4:0] h_ctx = hp_adr[8:4];
  wire [2:0] h_q = hp_adr[3:1];
  wire h_hi = ~hp_wide & hp_adr[0];
  wire h_rw = (h_q <= CCD_Q_LAST_RW);
  wire h_ro = (h_q >= CCD_Q_RES0);
  wire [63:0] h_old = h_rw ? desc_r[ccd_idx(h_ctx, h_q)] : 64'h0;
  // A narrow port needs two writes per word, which halves search rate
  wire [63:0] h_new = hp_wide ? hp_wdata :
                      h_hi ? {hp_wdata[31:0], h_old[31:0]} :
                      {h_old[63:32], hp_wdata[31:0]};
  wire h_wr_ok = hp_wr & h_rw;
  // A narrow port starts on the low half, which holds the start bit
  wire h_start = h_wr_ok & (h_q == CCD_Q_CMD) & ~h_hi & h_new[CCD_START_BIT];
  wire [63:0] h_rword = h_rw ? h_old :
                        h_ro ? res_r[{h_ctx, h_q[0]}] : 64'h0;
  wire [63:0] h_rsel = hp_wide ? h_rword :
                       {32'h0, h_hi ? h_rword[63:32] : h_rword[31:0]};

  // Current descriptor decode
  wire [63:0] c_cmd = desc_r[ccd_idx(cur_r, CCD_Q_CMD)];
  wire [63:0] c_d0 = desc_r[ccd_idx(cur_r, CCD_Q_D0)];
  // Bits 7 to 3 are not looked at; the host keeps them zero
  wire ccd_op_t c_op = ccd_op_t'(c_cmd[2:0]);
  wire ccd_size_t c_size = ccd_size_t'(c_cmd[CCD_SIZE_LSB +: 2]);
  wire ccd_loc_t c_loc = ccd_loc_t'(c_cmd[CCD_LOC_LSB +: 2]);
  wire c_srch = (c_op == CCD_SE) | (c_op == CCD_LE);
  wire c_rdwr = (c_op == CCD_RD) | (c_op == CCD_WR);
  wire c_usloc = c_rdwr | (c_op == CCD_MV) | (c_op == CCD_SW);
  // Illegal codes and sizes are refused rather than sent on
  wire c_bad = (c_op == CCD_BAD6) | (c_op == CCD_BAD7) |
               (c_srch & (c_size == CCD_XRSV)) |
               ((c_op == CCD_LE) & (c_size == CCD_X272));
  // Size is ignored outside Search and Learn
  wire ccd_size_t c_usize = c_srch ? c_size : CCD_X68;
  // A search at x68 sends Data 0 twice (cycles A and B), x136 two words, x272 four; other commands send one beat
  wire [1:0] c_lastb = (c_op != CCD_SE) ? 2'h0 :
                       (c_usize == CCD_X272) ? 2'h3 : 2'h1;
  wire [1:0] c_dw = (c_op == CCD_WR) ? 2'h1 :
                    ((c_op == CCD_SE) && (c_usize != CCD_X68)) ? beat_r : 2'h0;
  wire [2:0] c_word = CCD_Q_D0 + {1'b0, c_dw};
  wire [63:0] c_dat = desc_r[ccd_idx(cur_r, c_word)];
  wire [3:0] c_nib = c_cmd[CCD_NIB_LSB + 4*c_dw +: 4];
  // Data word above its own nibble; later beats of x136 and x272 carry higher words
  wire [67:0] c_key = ((c_op == CCD_SE) | (c_op == CCD_WR)) ?
                      {c_dat, c_nib} : 68'h0;
  // Second half of a wide search moves to the next mask pair
  wire [2:0] c_gmr = c_cmd[CCD_GMR_LSB +: 3] + {2'h0, beat_r[1]};
  wire c_end = (state_r == CCD_SEND) & (c_bad | (beat_r == c_lastb));
  wire c_bad_end = (state_r == CCD_SEND) & c_bad;
  wire go = (state_r == CCD_IDLE) & (|pend_r);
  wire [4:0] pick = ccd_pick(pend_r);

  always_comb begin
    req_nxt = CCD_REQ_IDLE;
    if ((state_r == CCD_SEND) && !c_bad) begin
      req_nxt.valid = 1'b1;
      req_nxt.op = c_op;
      req_nxt.size = c_usize;
      req_nxt.loc = c_usloc ? c_loc : CCD_LOC_DATA;
      req_nxt.indirect = c_rdwr & c_cmd[CCD_IND_BIT];
      req_nxt.sel = c_d0[CCD_SEL_LSB +: 5];
      req_nxt.addr = c_d0[CCD_ADDR_LSB +: 16];
      req_nxt.slot = cur_r;
      req_nxt.cid = c_cmd[CCD_CID_LSB +: 5];
      req_nxt.hid = c_cmd[CCD_HID_LSB +: 5];
      req_nxt.beat = beat_r;
      req_nxt.last = (beat_r == c_lastb);
      req_nxt.global_mask_pair = c_gmr;
      req_nxt.hit_index_register = c_cmd[CCD_SSR_LSB +: 3];
      req_nxt.cmp = c_srch ? c_cmd[CCD_CMP_LSB +: 4] : 4'h0;
      req_nxt.pfx = (c_srch | (c_usloc && c_loc == CCD_LOC_SRAM)) ?
                    c_cmd[CCD_PFX_LSB +: 3] : 3'h0;
      req_nxt.key = c_key;
      req_nxt.param = c_d0;
    end
  end

  // The next search starts while the engine still answers the last one
  assign state_nxt = go ? CCD_SEND : c_end ? CCD_IDLE : state_r;
  assign cur_nxt = go ? pick : cur_r;
  assign beat_nxt = go ? 2'h0 :
                    ((state_r == CCD_SEND) && !c_end) ? 2'(beat_r + 2'h1) : beat_r;
  // A fresh start in the finishing cycle survives the clear
  assign pend_nxt = (pend_r & ~(c_end ? (32'h1 << cur_r) : 32'h0)) |
                    (h_start ? (32'h1 << h_ctx) : 32'h0);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= CCD_IDLE;
      cur_r <= 5'h00;
      beat_r <= 2'h0;
      pend_r <= 32'h0;
      req_r <= CCD_REQ_IDLE;
      hp_rdata_r <= 64'h0;
      hp_rvalid_r <= 1'b0;
      busy_r <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      cur_r <= cur_nxt;
      beat_r <= beat_nxt;
      pend_r <= pend_nxt;
      req_r <= req_nxt;
      hp_rdata_r <= hp_rd ? h_rsel : hp_rdata_r;
      hp_rvalid_r <= hp_rd;
      busy_r <= (state_nxt == CCD_SEND) | (|pend_nxt);
    end
  end

  // Storage has no reset; software fills a context before starting it
  always_ff @(posedge mclk) begin
    if (ce) begin
      if (h_wr_ok) begin
        desc_r[ccd_idx(h_ctx, h_q)] <= h_new;
      end
      if (go) begin
        res_r[{pick, 1'b0}] <= 64'h0;
      end
      if (c_bad_end) begin
        res_r[{cur_r, 1'b0}] <= ccd_res0(c_cmd, 1'b1, 4'h0);
      end
      if (eng_rsp.valid) begin
        res_r[{eng_rsp.slot, 1'b0}] <= ccd_res0(desc_r[ccd_idx(eng_rsp.slot, CCD_Q_CMD)],
                                                eng_rsp.err, eng_rsp.data[3:0]);
        res_r[{eng_rsp.slot, 1'b1}] <= eng_rsp.data[67:4];
      end
    end
  end

  assign hp_rdata = hp_rdata_r;
  assign hp_rvalid = hp_rvalid_r;
  assign eng_req = req_r;
  assign busy = busy_r;

  op_legal_a: assert property (@(posedge mclk) disable iff (!reset_n)
    eng_req.valid |-> (eng_req.op <= CCD_SW))
    else $error("illegal operation issued");

  start_begin_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (ce && state_r == CCD_IDLE && pend_r == 32'h0 && h_start) ##1 ce |=>
      (state_r == CCD_SEND) && (cur_r == $past(h_ctx, 2)))
    else $error("start did not begin operation");

  x68_beats_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (eng_req.valid && eng_req.op == CCD_SE && eng_req.size != CCD_X272 && eng_req.beat == 2'h1)
      |-> eng_req.last)
    else $error("short search not ended after two beats");

  x68_repeat_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ($past(ce) && eng_req.valid && eng_req.op == CCD_SE && eng_req.size == CCD_X68
      && eng_req.beat == 2'h1) |-> (eng_req.key == $past(eng_req.key)))
    else $error("x68 key differs between beats");

  gmr_wrap_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ($past(ce) && $past(ce, 2) && eng_req.valid && eng_req.op == CCD_SE && eng_req.beat == 2'h2)
      |-> (eng_req.global_mask_pair == 3'($past(eng_req.global_mask_pair, 2) + 3'h1)))
    else $error("mask pair not advanced");

  cmp_search_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (eng_req.valid && eng_req.op != CCD_SE && eng_req.op != CCD_LE)
      |-> (eng_req.cmp == 4'h0) && (eng_req.size == CCD_X68))
    else $error("comparand index or size outside search");

  indirect_rw_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (eng_req.valid && eng_req.indirect) |-> (eng_req.op == CCD_RD || eng_req.op == CCD_WR))
    else $error("indirect on wrong command");

  bad_no_access_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (ce && c_bad_end) |=> !eng_req.valid && (state_r == CCD_IDLE))
    else $error("bad command reached engines");

  busy_send_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (state_r == CCD_SEND) |-> busy)
    else $error("busy low while sending");

  start_busy_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (ce && h_start) |=> busy)
    else $error("start not shown as busy");

  read_answer_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (ce && hp_rd) |=> hp_rvalid)
    else $error("read not answered");

  rvalid_pulse_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (ce && !hp_rd) |=> !hp_rvalid)
    else $error("read valid without read");

  rdata_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !hp_rd |=> $stable(hp_rdata))
    else $error("read data changed without read");

  narrow_upper_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (ce && hp_rd && !hp_wide) |=> (hp_rdata[63:32] == 32'h0))
    else $error("narrow read upper half not zero");

  write_single_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (eng_req.valid && eng_req.op == CCD_WR) |-> eng_req.last && (eng_req.beat == 2'h0))
    else $error("write not sent as one beat");

  search_region_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (eng_req.valid && (eng_req.op == CCD_SE || eng_req.op == CCD_LE)) |-> (eng_req.loc == CCD_LOC_DATA))
    else $error("region set on search or learn");

  learn_size_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (eng_req.valid && eng_req.op == CCD_LE) |-> (eng_req.size == CCD_X68 || eng_req.size == CCD_X136))
    else $error("learn sent with wide size");

  beat_step_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (ce && eng_req.valid && !eng_req.last) |=>
      eng_req.valid && (eng_req.beat == 2'($past(eng_req.beat) + 2'h1)))
    else $error("search beats not consecutive");

  op_gap_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (ce && eng_req.valid && eng_req.last) |=> !eng_req.valid)
    else $error("no idle cycle after operation");

  ids_steady_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (ce && eng_req.valid && !eng_req.last) |=>
      (eng_req.cid == $past(eng_req.cid)) && (eng_req.hid == $past(eng_req.hid)))
    else $error("identifiers changed within operation");

endmodule

/* File: tb/ccd_engine_model.sv */
`timescale 1ns/10ps
module ccd_engine_model
  import ccd_pkg::*;
(
  input wire logic mclk,
  input wire logic slow,
  input wire ccd_req_t eng_req,
  output ccd_rsp_t eng_rsp
);
  // Delay line, so a slow answer comes back five cycles after a prompt one
  ccd_rsp_t pipe_r [8] = '{default: '0};
  always @(posedge mclk) begin
    for (int n = 0; n < 7; n++) begin
      pipe_r[n] <= pipe_r[n + 1];
    end
    pipe_r[7] <= '0;
    if (eng_req.valid === 1'b1 && eng_req.last === 1'b1) begin
      pipe_r[slow ? 5 : 0] <= '{1'b1, eng_req.slot, 1'b0, {eng_req.param, 4'hA}};
    end
  end
  assign eng_rsp = pipe_r[0];
endmodule

/* File: tb/context_command_decoder_test.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; $display("Error t=%0t got %h exp %h", $time, a, b); end end
module context_command_decoder_test
  import ccd_pkg::*;
;
  typedef struct {ccd_op_t op; logic [1:0] sz, loc; logic ind; logic [2:0] g, ge; int ctx, n; logic [6:0] pc; logic e;} ccd_row_t;
  localparam logic [15:0] NIB = 16'h7A3C;
  localparam logic [63:0] RES0 = {27'h0, 5'h0A, 3'h4, 5'h15, 20'h0, 4'hA};
  ccd_row_t rows[11] = '{
    '{CCD_RD, 0, 2, 1, 0, 0, 1, 1, 7'h60, 0},
    '{CCD_WR, 0, 1, 0, 3, 3, 2, 1, 7'h00, 0},
    '{CCD_SE, 0, 0, 0, 2, 2, 3, 2, 7'h69, 0},
    '{CCD_SE, 1, 0, 0, 2, 2, 4, 2, 7'h69, 0},
    '{CCD_SE, 2, 0, 0, 7, 0, 5, 4, 7'h69, 0},
    '{CCD_LE, 1, 0, 0, 0, 0, 6, 1, 7'h69, 0},
    '{CCD_MV, 0, 3, 0, 4, 4, 7, 1, 7'h00, 0},
    '{CCD_SW, 0, 0, 0, 5, 5, 8, 1, 7'h00, 0},
    '{CCD_BAD6, 0, 0, 0, 0, 0, 9, 0, 7'h00, 1},
    '{CCD_BAD7, 0, 0, 0, 0, 0, 10, 0, 7'h00, 1},
    '{CCD_LE, 2, 0, 0, 0, 0, 11, 0, 7'h00, 1}
  };
  logic mclk = 0, reset_n = 0, ce = 1, hp_wr = 0, hp_rd = 0, hp_wide = 1, slow = 0;
  logic [8:0] hp_adr = '0;
  logic [63:0] hp_wdata = '0, hp_rdata, rd, d0, c;
  logic hp_rvalid, busy;
  ccd_req_t eng_req;
  ccd_rsp_t eng_rsp;
  ccd_req_t beats[$];
  int bt[$];
  int fails = 0, comparisons = 0, cyc = 0;
  ccd_top ccd_top_inst (.mclk(mclk), .reset_n(reset_n), .ce(ce), .hp_wr(hp_wr), .hp_rd(hp_rd),
    .hp_adr(hp_adr), .hp_wdata(hp_wdata), .hp_wide(hp_wide), .hp_rdata(hp_rdata),
    .hp_rvalid(hp_rvalid), .eng_req(eng_req), .eng_rsp(eng_rsp), .busy(busy));
  ccd_engine_model ccd_engine_model_inst (.mclk(mclk), .slow(slow), .eng_req(eng_req), .eng_rsp(eng_rsp));
  initial forever #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (eng_req.valid === 1'b1) begin
      beats.push_back(eng_req);
      bt.push_back(cyc);
    end
  end
  function automatic logic [63:0] dw(int k);
    return 64'h0F1E_2D3C_4B9A_1234 + 64'(k) * 64'h0100_0000_0000_0001;
  endfunction
  function automatic logic [63:0] cmd(ccd_row_t r);
    return {8'h15, 8'h0A, 5'h0A, r.g, 8'h69, 2'h0, r.ind, r.loc, r.sz, 1'b1, NIB, 5'h0, r.op};
  endfunction
  task automatic bus(input logic w, input logic [8:0] a, input logic [63:0] d);
    hp_wr = w;
    hp_rd = !w;
    hp_adr = a;
    hp_wdata = d;
    @(posedge mclk);
    #1;
    rd = hp_rdata;
  endtask
  task automatic idle;
    hp_wr = 0;
    hp_rd = 0;
    @(posedge mclk);
    #1;
  endtask
  task automatic rdw(input logic [8:0] a);
    bus(0, a, '0);
    `CHK(hp_rvalid, 1'b1)
    idle();
    `CHK(hp_rvalid, 1'b0)
  endtask
  task automatic wait_done(input logic [8:0] a);
    rd = '0;
    for (int i = 0; i < 20 && rd[31] !== 1'b1; i++) rdw(a);
  endtask
  task automatic print_verdict;
    $display("Counts: %0d compared, %0d failed", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    print_verdict();
  end
  initial begin
    ccd_row_t r;
    ccd_req_t q;
    logic [8:0] a;
    int kx;
    d0 = dw(0);
    repeat (5) @(posedge mclk);
    #1;
    `CHK({busy, hp_rvalid, eng_req}, '0)
    reset_n = 1;
    $display("Test reset done");
    foreach (rows[i]) begin
      r = rows[i];
      a = 9'(r.ctx * 16);
      slow = i[0];
      for (int k = 0; k < 4; k++) bus(1, a + 9'(2 * k + 2), dw(k));
      beats.delete();
      bus(1, a, cmd(r));
      `CHK(busy, 1'b1)
      idle();
      wait_done(a + 9'hC);
      `CHK(busy, 1'b0)
      `CHK(rd[31:30], {1'b1, r.e})
      `CHK(beats.size(), r.n)
      if (!r.e) begin
        `CHK(rd, RES0)
        rdw(a + 9'hE);
        `CHK(rd, d0)
        q = beats[r.n - 1];
        kx = (r.op == CCD_WR || r.sz == 1) ? 1 : (r.sz == 2) ? 3 : 0;
        `CHK({q.op, q.size, q.loc, q.indirect}, {r.op, r.sz, r.loc, r.ind})
        `CHK({q.pfx, q.cmp, q.global_mask_pair}, {r.pc, r.ge})
        `CHK({q.slot, q.cid, q.hid, q.last}, {5'(r.ctx), 5'h15, 5'h0A, 1'b1})
        `CHK({q.hit_index_register, q.beat, q.param}, {3'h5, 2'(r.n - 1), d0})
        `CHK({q.sel, q.addr}, {d0[23:19], d0[15:0]})
        if (r.op inside {CCD_WR, CCD_SE}) `CHK(q.key, {dw(kx), NIB[4 * kx +: 4]})
      end
      $display("Row %0d done", i);
    end
    rdw(9'h1A);
    `CHK(rd, 64'h0)
    bus(1, 9'h1C, '1);
    idle();
    rdw(9'h1C);
    `CHK(rd, RES0)
    rdw(9'h12);
    `CHK(rd, d0)
    $display("Test map done");
    hp_wide = 0;
    a = 9'h0D0;
    beats.delete();
    c = cmd(rows[2]);
    bus(1, a + 9'h2, d0);
    bus(1, a + 9'h3, d0 >> 32);
    bus(1, a + 9'h1, c >> 32);
    bus(1, a, c);
    idle();
    rdw(a + 9'h3);
    `CHK(rd, d0 >> 32)
    wait_done(a + 9'hC);
    hp_wide = 1;
    `CHK(beats.size(), 2)
    `CHK(beats[0].key, {d0, NIB[3:0]})
    $display("Test narrow done");
    beats.delete();
    bt.delete();
    for (int k = 14; k < 17; k++) bus(1, 9'(k * 16 + 2), d0);
    for (int k = 14; k < 17; k++) bus(1, 9'(k * 16), c);
    idle();
    wait_done(9'h10C);
    `CHK(bt.size(), 6)
    `CHK({bt[2] - bt[0], bt[4] - bt[2]}, {32'd3, 32'd3})
    $display("Test pipeline done");
    beats.delete();
    bus(1, 9'h142, d0);
    bus(1, 9'h140, c);
    idle();
    reset_n = 0;
    idle();
    `CHK({busy, hp_rvalid, eng_req}, '0)
    reset_n = 1;
    idle();
    idle();
    `CHK({busy, 32'(beats.size())}, {1'b0, 32'd0})
    $display("Test midreset done");
    bus(1, 9'h152, d0);
    bus(1, 9'h150, c);
    ce = 0;
    bus(1, 9'h160, c);
    idle();
    `CHK({busy, eng_req.valid, 32'(beats.size())}, {2'b10, 32'd0})
    ce = 1;
    wait_done(9'h15C);
    `CHK({busy, 32'(beats.size())}, {1'b0, 32'd2})
    $display("Test enable done");
    print_verdict();
  end
endmodule
